// ==== src/tng_pkg.sv ====
// Package: register map, field layout, reset values and source codes of the tone/noise block
package tng_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [9:0]  TNG_IDX_TONE_CTRL   = 10'h020;
  localparam logic [9:0]  TNG_IDX_TONE_A_HIGH = 10'h021;
  localparam logic [9:0]  TNG_IDX_TONE_A_LOW  = 10'h022;
  localparam logic [9:0]  TNG_IDX_TONE_B_HIGH = 10'h023;
  localparam logic [9:0]  TNG_IDX_TONE_B_LOW  = 10'h024;
  localparam logic [9:0]  TNG_IDX_HISS_CTRL   = 10'h0a0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          TNG_BIT_BEEP_A_ON   = 0;
  localparam int          TNG_BIT_BEEP_B_ON   = 1;
  localparam int          TNG_BIT_BEEP_A_OVD  = 4;
  localparam int          TNG_BIT_BEEP_B_OVD  = 5;
  localparam int          TNG_POS_PHASE_LO    = 8;
  localparam int          TNG_BIT_HISS_ON     = 5;
  localparam int          TNG_POS_HISS_LVL_LO = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] TNG_RST_TONE_CTRL   = 16'h0000;
  localparam logic [15:0] TNG_RST_LEVEL_HIGH  = 16'h1000;
  localparam logic [7:0]  TNG_RST_LEVEL_LOW   = 8'h00;
  localparam logic [15:0] TNG_RST_HISS_CTRL   = 16'h0000;

  // ************************************************************
  // Levels and codes
  // ************************************************************
  localparam logic [4:0]  TNG_HISS_LVL_MAX    = 5'h12;
  localparam logic [7:0]  TNG_SRC_TONE_A      = 8'h04;
  localparam logic [7:0]  TNG_SRC_TONE_B      = 8'h05;
  localparam logic [7:0]  TNG_SRC_HISS        = 8'h0d;
  localparam int          TNG_TONE_FREQ_HZ    = 1000;
  localparam int          TNG_FS_HZ_DEFAULT   = 48000;
  localparam logic [22:0] TNG_LFSR_SEED       = 23'h00_0001;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } tng_apb_req_t;

  typedef struct packed {
    logic        tick;
    logic [23:0] data;
  } tng_sample_t;

endpackage : tng_pkg

// ==== src/tng_top.sv ====
// Module: dual 1 kHz tone source and comfort-noise source with APB register slave
// Operation
// - Two 1 kHz sines, second phase configurable
// - Each tone selectable by mixer source code
// - Tone enables bits 0/1, reset off
// - Bits 9:8 advance tone B 0-270 degrees
// - Override bits 4/5 force DC level while the tone is enabled
// - DC level 24-bit signed, high/low registers
// - Full scale is 0x10_0000 / 0xF0_0000
// - White noise selectable with code 0x0D
// - Noise only while bit 5 set, reset off
// - Noise level -108 to 0 dBFS, 6 dB steps
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module tng_top #(
  parameter int FS_HZ   = tng_pkg::TNG_FS_HZ_DEFAULT,
  parameter int NUM_SEL = 4
) (
  // Clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  // APB slave
  input  wire tng_pkg::tng_apb_req_t apb_req_i,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic [31:0]                prdata_o,
  // Sample-rate strobes from the core rate generator
  input  wire logic                  tone_tick_i,
  input  wire logic                  hiss_tick_i,
  // Source outputs
  output tng_pkg::tng_sample_t       tone_a_o,
  output tng_pkg::tng_sample_t       tone_b_o,
  output tng_pkg::tng_sample_t       hiss_o,
  // Mixer input selectors
  input  wire logic [7:0]            mixer_input_select_i [NUM_SEL],
  output logic [23:0]                mixer_sample_o       [NUM_SEL]
);
  import tng_pkg::*;

  // ************************************************************
  // Constants
  // ************************************************************
  localparam logic [31:0] PHASE_STEP =
    32'((64'(TNG_TONE_FREQ_HZ) << 32) / 64'(FS_HZ));

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] tone_ctrl_r;
  logic [15:0] lvl_a_high_r;
  logic [7:0]  lvl_a_low_r;
  logic [15:0] lvl_b_high_r;
  logic [7:0]  lvl_b_low_r;
  logic [15:0] hiss_ctrl_r;
  logic        data_ok_r;
  logic [31:0] prdata_r;
  logic [31:0] phase_r;
  logic [22:0] lfsr_r;
  logic [23:0] tone_a_r;
  logic [23:0] tone_b_r;
  logic [23:0] hiss_r;
  logic        tone_tick_r;
  logic        hiss_tick_r;

  logic        beep_a_on;
  logic        beep_b_on;
  logic        beep_a_dc_override;
  logic        beep_b_dc_override;
  logic [1:0]  phase_offset;
  logic [23:0] beep_a_dc_level;
  logic [23:0] beep_b_dc_level;
  logic        hiss_on;
  logic [4:0]  hiss_level;
  logic [31:0] phase_b;
  logic [23:0] tone_a_nxt;
  logic [23:0] tone_b_nxt;
  logic [23:0] hiss_nxt;
  logic [4:0]  hiss_lvl_eff;
  logic [4:0]  hiss_shift;
  logic [23:0] hiss_raw;
  logic        hit;
  logic        wr_en;
  logic [9:0]  idx;

  // ************************************************************
  // Functions
  // ************************************************************
  // Quarter-wave table, 0 dBFS = 0x10_0000
  function automatic logic [23:0] tng_quarter(input logic [4:0] k);
    unique case (k)
      5'd0:    tng_quarter = 24'd0;
      5'd1:    tng_quarter = 24'd102778;
      5'd2:    tng_quarter = 24'd204567;
      5'd3:    tng_quarter = 24'd304385;
      5'd4:    tng_quarter = 24'd401273;
      5'd5:    tng_quarter = 24'd494295;
      5'd6:    tng_quarter = 24'd582558;
      5'd7:    tng_quarter = 24'd665209;
      5'd8:    tng_quarter = 24'd741455;
      5'd9:    tng_quarter = 24'd810559;
      5'd10:   tng_quarter = 24'd871864;
      5'd11:   tng_quarter = 24'd924765;
      5'd12:   tng_quarter = 24'd968758;
      5'd13:   tng_quarter = 24'd1003425;
      5'd14:   tng_quarter = 24'd1028428;
      5'd15:   tng_quarter = 24'd1043527;
      default: tng_quarter = 24'h10_0000;
    endcase
  endfunction : tng_quarter

  // Full sine from top six phase bits, used for both tones
  function automatic logic [23:0] tng_sine(input logic [5:0] ph);
    logic [4:0]  k;
    logic [23:0] mag;
    k   = 5'b0_0000;
    mag = 24'h00_0000;
    k   = ph[4] ? 5'(5'd16 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
    mag = tng_quarter(k);
    tng_sine = ph[5] ? 24'(-mag) : mag;
  endfunction : tng_sine

  // Register read decode, used by the read latch; the hit check uses tng_mapped
  function automatic logic [31:0] tng_read(input logic [9:0] i);
    unique case (i)
      TNG_IDX_TONE_CTRL:   tng_read = {16'h0000, tone_ctrl_r};
      TNG_IDX_TONE_A_HIGH: tng_read = {16'h0000, lvl_a_high_r};
      TNG_IDX_TONE_A_LOW:  tng_read = {24'h00_0000, lvl_a_low_r};
      TNG_IDX_TONE_B_HIGH: tng_read = {16'h0000, lvl_b_high_r};
      TNG_IDX_TONE_B_LOW:  tng_read = {24'h00_0000, lvl_b_low_r};
      TNG_IDX_HISS_CTRL:   tng_read = {16'h0000, hiss_ctrl_r};
      default:             tng_read = 32'h0000_0000;
    endcase
  endfunction : tng_read

  function automatic logic tng_mapped(input logic [9:0] i);
    tng_mapped = (i == TNG_IDX_TONE_CTRL) || (i == TNG_IDX_TONE_A_HIGH) ||
                 (i == TNG_IDX_TONE_A_LOW) || (i == TNG_IDX_TONE_B_HIGH) ||
                 (i == TNG_IDX_TONE_B_LOW) || (i == TNG_IDX_HISS_CTRL);
  endfunction : tng_mapped

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] tng_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  strb);
    tng_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction : tng_merge

  // ************************************************************
  // APB slave
  // ************************************************************
  assign idx       = apb_req_i.paddr[11:2];
  assign hit       = tng_mapped(idx);
  // Read data is latched one cycle ahead so prdata comes from a flop
  assign pready_o  = ce_i & data_ok_r;
  assign pslverr_o = pready_o & ~hit;
  assign prdata_o  = prdata_r;
  assign wr_en     = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite &
                     pready_o & hit;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      data_ok_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce_i) begin
      data_ok_r <= apb_req_i.psel & ~(apb_req_i.penable & pready_o);
      if (apb_req_i.psel) begin
        prdata_r <= apb_req_i.pwrite ? 32'h0000_0000 : tng_read(idx);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tone_ctrl_r <= TNG_RST_TONE_CTRL;
      hiss_ctrl_r <= TNG_RST_HISS_CTRL;
    end else if (ce_i && wr_en) begin
      // Unused bits are not stored, so they read as zero
      if (idx == TNG_IDX_TONE_CTRL) begin
        tone_ctrl_r <= tng_merge(tone_ctrl_r, apb_req_i.pwdata[15:0],
                                 apb_req_i.pstrb[1:0]) & 16'h0333;
      end
      if (idx == TNG_IDX_HISS_CTRL) begin
        hiss_ctrl_r <= tng_merge(hiss_ctrl_r, apb_req_i.pwdata[15:0],
                                 apb_req_i.pstrb[1:0]) & 16'h003f;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lvl_a_high_r <= TNG_RST_LEVEL_HIGH;
      lvl_a_low_r  <= TNG_RST_LEVEL_LOW;
      lvl_b_high_r <= TNG_RST_LEVEL_HIGH;
      lvl_b_low_r  <= TNG_RST_LEVEL_LOW;
    end else if (ce_i && wr_en) begin
      if (idx == TNG_IDX_TONE_A_HIGH) begin
        lvl_a_high_r <= tng_merge(lvl_a_high_r, apb_req_i.pwdata[15:0],
                                  apb_req_i.pstrb[1:0]);
      end
      if (idx == TNG_IDX_TONE_A_LOW && apb_req_i.pstrb[0]) begin
        lvl_a_low_r <= apb_req_i.pwdata[7:0];
      end
      if (idx == TNG_IDX_TONE_B_HIGH) begin
        lvl_b_high_r <= tng_merge(lvl_b_high_r, apb_req_i.pwdata[15:0],
                                  apb_req_i.pstrb[1:0]);
      end
      if (idx == TNG_IDX_TONE_B_LOW && apb_req_i.pstrb[0]) begin
        lvl_b_low_r <= apb_req_i.pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  assign beep_a_on          = tone_ctrl_r[TNG_BIT_BEEP_A_ON];
  assign beep_b_on          = tone_ctrl_r[TNG_BIT_BEEP_B_ON];
  assign beep_a_dc_override = tone_ctrl_r[TNG_BIT_BEEP_A_OVD];
  assign beep_b_dc_override = tone_ctrl_r[TNG_BIT_BEEP_B_OVD];
  assign phase_offset       = tone_ctrl_r[TNG_POS_PHASE_LO +: 2];
  assign beep_a_dc_level    = {lvl_a_high_r, lvl_a_low_r};
  assign beep_b_dc_level    = {lvl_b_high_r, lvl_b_low_r};
  assign hiss_on            = hiss_ctrl_r[TNG_BIT_HISS_ON];
  assign hiss_level         = hiss_ctrl_r[TNG_POS_HISS_LVL_LO +: 5];

  // ************************************************************
  // Tone synthesis
  // ************************************************************
  // Quarter-turn offset lands in the top two phase bits
  assign phase_b = phase_r + {phase_offset, 30'h0000_0000};

  always_comb begin
    tone_a_nxt = 24'h00_0000;
    tone_b_nxt = 24'h00_0000;
    if (beep_a_on) begin
      tone_a_nxt = beep_a_dc_override ? beep_a_dc_level
                                      : tng_sine(phase_r[31:26]);
    end
    if (beep_b_on) begin
      tone_b_nxt = beep_b_dc_override ? beep_b_dc_level
                                      : tng_sine(phase_b[31:26]);
    end
  end

  // Accumulator free-runs so both tones stay locked when toggled
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phase_r     <= 32'h0000_0000;
      tone_a_r    <= 24'h00_0000;
      tone_b_r    <= 24'h00_0000;
      tone_tick_r <= 1'b0;
    end else if (ce_i) begin
      tone_tick_r <= tone_tick_i;
      if (tone_tick_i) begin
        phase_r  <= phase_r + PHASE_STEP;
        tone_a_r <= tone_a_nxt;
        tone_b_r <= tone_b_nxt;
      end
    end
  end

  // ************************************************************
  // Noise synthesis
  // ************************************************************
  // Reserved level codes clamp to 0 dBFS rather than overflow
  assign hiss_lvl_eff = (hiss_level > TNG_HISS_LVL_MAX) ? TNG_HISS_LVL_MAX : hiss_level;
  assign hiss_shift   = 5'(TNG_HISS_LVL_MAX - hiss_lvl_eff);
  // 21 signed bits span -full scale to one step below +full scale
  assign hiss_raw     = {{3{lfsr_r[20]}}, lfsr_r[20:0]};
  assign hiss_nxt     = hiss_on ? 24'($signed(hiss_raw) >>> hiss_shift)
                                : 24'h00_0000;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lfsr_r      <= TNG_LFSR_SEED;
      hiss_r      <= 24'h00_0000;
      hiss_tick_r <= 1'b0;
    end else if (ce_i) begin
      hiss_tick_r <= hiss_tick_i;
      if (hiss_tick_i) begin
        // x^23 + x^18 + 1, maximal length
        lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
        hiss_r <= hiss_nxt;
      end
    end
  end

  assign tone_a_o = '{tick: tone_tick_r, data: tone_a_r};
  assign tone_b_o = '{tick: tone_tick_r, data: tone_b_r};
  assign hiss_o   = '{tick: hiss_tick_r, data: hiss_r};

  // ************************************************************
  // Mixer input selection
  // ************************************************************
  // Unknown codes give silence; other core sources are muxed elsewhere
  for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
    logic [23:0] sel_r;
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        sel_r <= 24'h00_0000;
      end else if (ce_i) begin
        unique case (mixer_input_select_i[g])
          TNG_SRC_TONE_A: sel_r <= tone_a_r;
          TNG_SRC_TONE_B: sel_r <= tone_b_r;
          TNG_SRC_HISS:   sel_r <= hiss_r;
          default:        sel_r <= 24'h00_0000;
        endcase
      end
    end
    assign mixer_sample_o[g] = sel_r;
  end

endmodule : tng_top

// ==== sim/tng_top_properties.sv ====
// Checker: port-level properties of the tone and noise block
`timescale 1ns/1ps
module tng_top_properties #(
  parameter int NUM_SEL = 4
) (
  // Clock, reset, enable
  input wire logic                  core_clk_i,
  input wire logic                  srst_i,
  input wire logic                  ce_i,
  // Register bus
  input wire tng_pkg::tng_apb_req_t apb_req_i,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic [31:0]           prdata_o,
  // Samples and mixers
  input wire logic                  tone_tick_i,
  input wire logic                  hiss_tick_i,
  input wire tng_pkg::tng_sample_t  tone_a_o,
  input wire tng_pkg::tng_sample_t  tone_b_o,
  input wire tng_pkg::tng_sample_t  hiss_o,
  input wire logic [7:0]            mixer_input_select_i [NUM_SEL],
  input wire logic [23:0]           mixer_sample_o       [NUM_SEL]
);
  import tng_pkg::*;
  logic mapped;
  assign mapped = apb_req_i.paddr inside {12'h080, 12'h084, 12'h088, 12'h08c, 12'h090, 12'h280};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ************************************************************
  // Properties
  // ************************************************************
  zero_wait_a:
    assert property (apb_req_i.psel && !apb_req_i.penable && ce_i ##1 ce_i |-> pready_o)
      else $error("access phase not completed at once");
  unmapped_err_a:
    assert property (pready_o |-> (pslverr_o == !mapped)) else $error("error flag wrong");
  write_data_zero_a:
    assert property (pready_o && apb_req_i.pwrite |-> prdata_o == 32'h0000_0000)
      else $error("read data on a write");
  tone_tick_a:
    assert property (tone_tick_i && ce_i |=> tone_a_o.tick && tone_b_o.tick)
      else $error("tone tick not forwarded");
  hiss_tick_a:
    assert property (hiss_tick_i && ce_i |=> hiss_o.tick) else $error("noise tick lost");
  tone_hold_a:
    assert property (!tone_tick_i |=> $stable(tone_a_o.data) && $stable(tone_b_o.data))
      else $error("tone moved without a tick");
  mix_zero_a:
    assert property (ce_i && mixer_input_select_i[3] == 8'h06 |=> mixer_sample_o[3] == 24'h00_0000)
      else $error("unused code not silent");
  mix_hiss_a:
    assert property (ce_i && mixer_input_select_i[2] == TNG_SRC_HISS
                     |=> mixer_sample_o[2] == $past(hiss_o.data)) else $error("noise not routed");
  cover property (pready_o && apb_req_i.pwrite);
  cover property (tone_a_o.tick);
  cover property (hiss_o.tick);
endmodule : tng_top_properties

bind tng_top tng_top_properties #(.NUM_SEL(NUM_SEL)) u_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .apb_req_i(apb_req_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
  .tone_tick_i(tone_tick_i), .hiss_tick_i(hiss_tick_i), .tone_a_o(tone_a_o),
  .tone_b_o(tone_b_o), .hiss_o(hiss_o), .mixer_input_select_i(mixer_input_select_i),
  .mixer_sample_o(mixer_sample_o));

// ==== sim/tng_rate_model.sv ====
// Partner model: core rate generator strobing the tone and noise sample rates
`timescale 1ns/1ps
module tng_rate_model #(
  parameter int TONE_DIV = 6,
  parameter int HISS_DIV = 9
) (
  // Clock and run
  input  wire logic core_clk_i,
  input  wire logic run_i,
  // Sample strobes
  output logic      tone_tick_o,
  output logic      hiss_tick_o
);
  int tone_cnt_r;
  int hiss_cnt_r;
  // Strobes share the core clock, so no rate converter sits between
  assign tone_tick_o = run_i && (tone_cnt_r == TONE_DIV - 1);
  assign hiss_tick_o = run_i && (hiss_cnt_r == HISS_DIV - 1);
  always_ff @(posedge core_clk_i) begin
    tone_cnt_r <= (tone_cnt_r == TONE_DIV - 1) ? 0 : tone_cnt_r + 1;
  end
  always_ff @(posedge core_clk_i) begin
    hiss_cnt_r <= (hiss_cnt_r == HISS_DIV - 1) ? 0 : hiss_cnt_r + 1;
  end
endmodule : tng_rate_model

// ==== sim/test_tone_and_noise_generator.sv ====
// Testbench: registers, tone, override and noise of the tone and noise block
`timescale 1ns/1ps
module test_tone_and_noise_generator;
  import tng_pkg::*;
  logic         clk;
  logic         srst;
  logic         ce;
  logic         run;
  tng_apb_req_t req;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  logic         ttick;
  logic         htick;
  tng_sample_t  ta;
  tng_sample_t  tb;
  tng_sample_t  hs;
  logic [7:0]   sel [4];
  logic [23:0]  mix [4];
  logic [23:0]  sa  [8];
  logic [23:0]  sb  [8];
  int           errors = 0;
  int           n_checks = 0;

  tng_rate_model u_rate (.core_clk_i(clk), .run_i(run), .tone_tick_o(ttick), .hiss_tick_o(htick));
  // Eight samples per tone period keep the phase arithmetic exact
  tng_top #(.FS_HZ(8000), .NUM_SEL(4)) uut (.core_clk_i(clk), .srst_i(srst), .ce_i(ce),
    .apb_req_i(req), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .tone_tick_i(ttick), .hiss_tick_i(htick), .tone_a_o(ta), .tone_b_o(tb), .hiss_o(hs),
    .mixer_input_select_i(sel), .mixer_sample_o(mix));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {16'h0000, wd}, 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    // Pre-edge values: what the slave shows at the completing edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      errors++;
      $display("mismatch apb ready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
    chk("write error", 32'h0000_0000, {31'h0, err});
  endtask : wr

  task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 16'h0000, rd, err);
    chk(what, exp, rd);
  endtask : rdc

  // First cycle skipped: a tick at the write edge still used old settings
  task automatic wait_tick(input logic noise);
    int n;
    n = 0;
    @(negedge clk);
    @(negedge clk);
    while ((noise ? hs.tick : ta.tick) !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    if ((noise ? hs.tick : ta.tick) !== 1'b1) begin
      errors++;
      $display("mismatch sample tick expected 1 seen 0");
    end
  endtask : wait_tick

  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    rdc("tone ctrl", TNG_IDX_TONE_CTRL, 32'h0000_0000);
    rdc("a high", TNG_IDX_TONE_A_HIGH, 32'h0000_1000);
    rdc("a low", TNG_IDX_TONE_A_LOW, 32'h0000_0000);
    rdc("b high", TNG_IDX_TONE_B_HIGH, 32'h0000_1000);
    rdc("b low", TNG_IDX_TONE_B_LOW, 32'h0000_0000);
    rdc("noise ctrl", TNG_IDX_HISS_CTRL, 32'h0000_0000);
    apb(1'b0, 10'h025, 16'h0000, rd, err);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    wr(TNG_IDX_TONE_CTRL, 16'hffff);
    rdc("ctrl mask", TNG_IDX_TONE_CTRL, 32'h0000_0333);
    wr(TNG_IDX_TONE_A_LOW, 16'hffff);
    rdc("low mask", TNG_IDX_TONE_A_LOW, 32'h0000_00ff);
    wr(TNG_IDX_HISS_CTRL, 16'hffff);
    rdc("noise mask", TNG_IDX_HISS_CTRL, 32'h0000_003f);
  endtask : t_regs

  task automatic t_dc();
    wr(TNG_IDX_TONE_A_LOW, 16'h005a);
    wr(TNG_IDX_TONE_B_HIGH, 16'hf000);
    wr(TNG_IDX_TONE_CTRL, 16'h0030);
    wait_tick(1'b0);
    chk("a off", 32'h0000_0000, {8'h0, ta.data});
    chk("b off", 32'h0000_0000, {8'h0, tb.data});
    wr(TNG_IDX_TONE_CTRL, 16'h0033);
    wait_tick(1'b0);
    chk("a dc", 32'h0010_005a, {8'h0, ta.data});
    chk("b dc", 32'h00f0_0000, {8'h0, tb.data});
    @(negedge clk);
    chk("mix a", 32'h0010_005a, {8'h0, mix[0]});
    chk("mix b", 32'h00f0_0000, {8'h0, mix[1]});
  endtask : t_dc

  task automatic t_phase();
    logic live;
    for (int off = 0; off < 4; off++) begin
      wr(TNG_IDX_TONE_CTRL, 16'h0003 | 16'(off << 8));
      for (int i = 0; i < 8; i++) begin
        wait_tick(1'b0);
        sa[i] = ta.data;
        sb[i] = tb.data;
      end
      live = |{sa[0], sa[1], sa[2]};
      chk("tone live", 32'h0000_0001, {31'h0, live});
      for (int i = 0; i < 8; i++) begin
        chk("half period", {8'h0, -sa[(i + 4) % 8]}, {8'h0, sa[i]});
        chk("b phase", {8'h0, sa[(i + 2 * off) % 8]}, {8'h0, sb[i]});
      end
    end
  endtask : t_phase

  task automatic t_hiss();
    logic [23:0] prev;
    wr(TNG_IDX_HISS_CTRL, 16'h0012);
    wait_tick(1'b1);
    chk("noise off", 32'h0000_0000, {8'h0, hs.data});
    wr(TNG_IDX_HISS_CTRL, 16'h0032);
    wait_tick(1'b1);
    prev = hs.data;
    wait_tick(1'b1);
    chk("noise moves", 32'h0000_0001, {31'h0, hs.data != prev});
    wr(TNG_IDX_HISS_CTRL, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      wait_tick(1'b1);
      chk("noise floor", 32'h0000_0001,
          {31'h0, ($signed(hs.data) >= -4) && ($signed(hs.data) <= 3)});
    end
  endtask : t_hiss

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    req = '0;
    sel = '{TNG_SRC_TONE_A, TNG_SRC_TONE_B, TNG_SRC_HISS, 8'h06};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    run <= 1'b1;
    t_regs();
    t_dc();
    t_phase();
    t_hiss();
    give_verdict();
  end

  // Whole run needs about 320 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule : test_tone_and_noise_generator
